/* File: verilog/acs_pkg.sv */
// Purpose: constants and types for the converter conversion sequencer
// Assumes: APB register access, 50 MHz pclk, 8-bit byte address
// Notes: converter timing is counted in half periods of the converter clock
//
// Functional notes
// - auto trigger restarts the converter prescaler
// - auto trigger samples after two cycles, 13.5 total
// - trigger passes three system clock synchronizer stages
// - free running restarts at completion, start stays high
// - normal 13 cycles, first conversion 25 cycles
// - selection copied from holding register until start
// - copying resumes in final converter clock cycle
// - software start waits for next converter rising edge
// - free running change affects the next conversion
// - halted sleep with idle converter starts a conversion
// - completion request raised even after early wakeup
// - other sleep modes never disable the converter
// - over-range input gives full scale code
// - completion stores result, sets done, clears start unless free running
// - trigger edges during a conversion are ignored
package acs_pkg;
	localparam logic [7:0] ACS_OFS_CTRL = 8'h00;
	localparam logic [7:0] ACS_OFS_SEL = 8'h04;
	localparam logic [7:0] ACS_OFS_DATA = 8'h08;
	localparam logic [7:0] ACS_OFS_STAT = 8'h0c;

	// control register bits
	localparam int ACS_B_EN = 0;
	localparam int ACS_B_START = 1;
	localparam int ACS_B_ATE = 2;
	localparam int ACS_B_FREE = 3;
	localparam int ACS_B_DONE = 4;
	localparam int ACS_B_IE = 5;
	localparam int ACS_B_PS = 6;
	localparam int ACS_PS_W = 3;
	// selection and status fields
	localparam int ACS_B_CHAN = 0;
	localparam int ACS_CHAN_W = 4;
	localparam int ACS_B_REF = 4;
	localparam int ACS_REF_W = 2;
	localparam int ACS_B_BUSY = 8;
	localparam int ACS_B_FIRST = 9;
	localparam int ACS_RES_W = 10;

	// converter timing in half periods of the converter clock
	localparam int ACS_CNT_W = 6;
	localparam logic [5:0] ACS_HALF_FIRST = 6'h32;
	localparam logic [5:0] ACS_SAMP_FIRST = 6'h1b;
	localparam logic [5:0] ACS_HALF_NORM = 6'h1a;
	localparam logic [5:0] ACS_SAMP_NORM = 6'h03;
	localparam logic [5:0] ACS_HALF_AUTO = 6'h1b;
	localparam logic [5:0] ACS_SAMP_AUTO = 6'h04;
	localparam logic [5:0] ACS_LAST_HALVES = 6'h02;

	localparam logic [9:0] ACS_FULL_SCALE = 10'h3ff;
	localparam logic [31:0] ACS_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [3:0] chan_sel;
	} acs_sel_t;

	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_WAIT_EDGE,
		ACS_CONV
	} acs_state_t;
endpackage

/* File: verilog/acs_prescaler.sv */
// Purpose: converter clock prescaler giving half period and rising edge pulses
// Assumes: clear held while converter disabled or pulsed on auto trigger
// Notes: division factor 2,2,4,8,...,128 by select code
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler #(
	parameter int CW = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic [2:0] div_sel,
	output logic half_tick,
	output logic rise
);
	logic [CW-1:0] cnt_r, cnt_nxt, half_len;
	logic phase_r, phase_nxt;
	logic tick_r, tick_nxt, rise_r, rise_nxt;

	always_comb begin
		half_len = (div_sel <= 3'h1) ? CW'(1) : CW'(CW'(1) << (div_sel - 3'h1));
		cnt_nxt = cnt_r;
		phase_nxt = phase_r;
		tick_nxt = 1'b0;
		rise_nxt = 1'b0;
		if (clr) begin
			cnt_nxt = '0;
			phase_nxt = 1'b0;
		end else if (cnt_r + CW'(1) >= half_len) begin
			cnt_nxt = '0;
			phase_nxt = ~phase_r;
			tick_nxt = 1'b1;
			rise_nxt = ~phase_r;
		end else begin
			cnt_nxt = cnt_r + CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			phase_r <= 1'b0;
			tick_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			tick_r <= tick_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign half_tick = tick_r;
	assign rise = rise_r;
endmodule // acs_prescaler
`default_nettype wire

/* File: verilog/acs_adc_conversion_sequencer.sv */
// Purpose: conversion sequencer of a 10-bit successive approximation converter
// Assumes: APB slave, trigger pin asynchronous, sleep and core inputs on pclk
// Notes: result and over-range flag come from the analog core at completion
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module acs_adc_conversion_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trig_in,
	input wire logic sleep_noise_mode,
	input wire logic cpu_halted,
	input wire logic over_range,
	input wire logic [9:0] core_result,
	output acs_pkg::acs_sel_t active_sel,
	output logic sample_hold,
	output logic conv_active,
	output logic conv_irq,
	output logic analog_on
);
	import acs_pkg::*;

	// register state
	logic en_r, en_nxt, ate_r, ate_nxt, free_r, free_nxt, ie_r, ie_nxt;
	logic done_r, done_nxt;
	logic [2:0] ps_r, ps_nxt;
	acs_sel_t hold_r, hold_nxt, act_r, act_nxt;
	logic [9:0] result_r, result_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	// sequencer state
	acs_state_t st_r, st_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic first_r, first_nxt, auto_r, auto_nxt;
	logic sample_r, sample_nxt, irq_r, irq_nxt, halt_r, halt_nxt;
	// trigger synchronizer
	logic trig_s1_r, trig_s2_r, trig_s3_r, trig_lvl_r, trig_lvl_nxt;
	logic trig_rise;
	// helpers
	logic wr, wr_ctrl, setup, hit, complete, unlock, presc_clr, auto_go;
	logic half_tick, adc_rise, free_mode;
	logic [5:0] len, samp;

	acs_prescaler #(.CW(7)) u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.clr(presc_clr),
		.div_sel(ps_r),
		.half_tick(half_tick),
		.rise(adc_rise)
	);

	// three stage synchronizer, level accepted once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
			trig_lvl_r <= 1'b0;
		end else begin
			trig_s1_r <= trig_in;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
			trig_lvl_r <= trig_lvl_nxt;
		end
	end

	always_comb begin
		trig_lvl_nxt = (trig_s2_r == trig_s3_r) ? trig_s3_r : trig_lvl_r;
		trig_rise = trig_s2_r & trig_s3_r & ~trig_lvl_r;
	end

	always_comb begin
		setup = psel & ~penable;
		wr = psel & penable & pready_r & pwrite;
		wr_ctrl = wr && (paddr == ACS_OFS_CTRL);
		hit = (paddr == ACS_OFS_CTRL) || (paddr == ACS_OFS_SEL) ||
			(paddr == ACS_OFS_DATA) || (paddr == ACS_OFS_STAT);
		free_mode = ate_r & free_r;
		if (first_r) begin
			len = ACS_HALF_FIRST;
			samp = ACS_SAMP_FIRST;
		end else if (auto_r) begin
			len = ACS_HALF_AUTO;
			samp = ACS_SAMP_AUTO;
		end else begin
			len = ACS_HALF_NORM;
			samp = ACS_SAMP_NORM;
		end
		complete = (st_r == ACS_CONV) && half_tick && (cnt_r + 6'h01 == len);
		unlock = cnt_r >= (len - ACS_LAST_HALVES);
		auto_go = en_r && ate_r && !free_r && trig_rise && (st_r != ACS_CONV);
		presc_clr = ~en_r | auto_go;
	end

	// register file
	always_comb begin
		en_nxt = en_r;
		ate_nxt = ate_r;
		free_nxt = free_r;
		ie_nxt = ie_r;
		ps_nxt = ps_r;
		hold_nxt = hold_r;
		prdata_nxt = prdata_r;
		pready_nxt = setup;
		pslverr_nxt = setup & ~hit;
		if (wr_ctrl) begin
			en_nxt = pwdata[ACS_B_EN];
			ate_nxt = pwdata[ACS_B_ATE];
			free_nxt = pwdata[ACS_B_FREE];
			ie_nxt = pwdata[ACS_B_IE];
			ps_nxt = pwdata[ACS_B_PS +: ACS_PS_W];
		end else if (wr && (paddr == ACS_OFS_SEL)) begin
			hold_nxt.chan_sel = pwdata[ACS_B_CHAN +: ACS_CHAN_W];
			hold_nxt.ref_sel = pwdata[ACS_B_REF +: ACS_REF_W];
		end
		if (setup) begin
			prdata_nxt = ACS_ZERO;
			if (paddr == ACS_OFS_CTRL) begin
				prdata_nxt[ACS_B_EN] = en_r;
				prdata_nxt[ACS_B_START] = (st_r != ACS_IDLE);
				prdata_nxt[ACS_B_ATE] = ate_r;
				prdata_nxt[ACS_B_FREE] = free_r;
				prdata_nxt[ACS_B_DONE] = done_r;
				prdata_nxt[ACS_B_IE] = ie_r;
				prdata_nxt[ACS_B_PS +: ACS_PS_W] = ps_r;
			end else if (paddr == ACS_OFS_SEL) begin
				prdata_nxt[ACS_B_CHAN +: ACS_CHAN_W] = hold_r.chan_sel;
				prdata_nxt[ACS_B_REF +: ACS_REF_W] = hold_r.ref_sel;
			end else if (paddr == ACS_OFS_DATA) begin
				prdata_nxt[ACS_RES_W-1:0] = result_r;
			end else if (paddr == ACS_OFS_STAT) begin
				prdata_nxt[ACS_B_CHAN +: ACS_CHAN_W] = act_r.chan_sel;
				prdata_nxt[ACS_B_REF +: ACS_REF_W] = act_r.ref_sel;
				prdata_nxt[ACS_B_BUSY] = (st_r == ACS_CONV);
				prdata_nxt[ACS_B_FIRST] = first_r;
			end
		end
	end

	// conversion sequencer
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		auto_nxt = auto_r;
		first_nxt = first_r;
		result_nxt = result_r;
		sample_nxt = 1'b0;
		halt_nxt = cpu_halted;
		act_nxt = act_r;
		done_nxt = done_r;
		if (wr_ctrl && pwdata[ACS_B_DONE])
			done_nxt = 1'b0;
		if (st_r != ACS_CONV || unlock)
			act_nxt = hold_r;
		if (!en_r)
			first_nxt = 1'b1;
		if (!en_r) begin
			st_nxt = ACS_IDLE;
			cnt_nxt = '0;
			if (wr_ctrl && pwdata[ACS_B_START] && pwdata[ACS_B_EN]) begin
				st_nxt = ACS_WAIT_EDGE;
				auto_nxt = 1'b0;
			end
		end else if (auto_go) begin
			st_nxt = ACS_CONV;
			cnt_nxt = '0;
			auto_nxt = 1'b1;
		end else begin
			case (st_r)
				ACS_IDLE: begin
					if (wr_ctrl && pwdata[ACS_B_START] && pwdata[ACS_B_EN]) begin
						st_nxt = ACS_WAIT_EDGE;
						auto_nxt = 1'b0;
					end else if (sleep_noise_mode && cpu_halted && !halt_r) begin
						st_nxt = ACS_WAIT_EDGE;
						auto_nxt = 1'b0;
					end
				end
				ACS_WAIT_EDGE: begin
					if (adc_rise) begin
						st_nxt = ACS_CONV;
						cnt_nxt = '0;
					end
				end
				ACS_CONV: begin
					if (half_tick) begin
						cnt_nxt = cnt_r + 6'h01;
						sample_nxt = (cnt_r + 6'h01 == samp);
					end
					if (complete) begin
						result_nxt = over_range ? ACS_FULL_SCALE : core_result;
						done_nxt = 1'b1;
						first_nxt = 1'b0;
						cnt_nxt = '0;
						auto_nxt = 1'b0;
						st_nxt = free_mode ? ACS_CONV : ACS_IDLE;
					end
				end
				default: st_nxt = ACS_IDLE;
			endcase
		end
		if (wr_ctrl && pwdata[ACS_B_EN] && !en_r)
			first_nxt = 1'b1;
		irq_nxt = done_nxt & ie_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 1'b0;
			ate_r <= 1'b0;
			free_r <= 1'b0;
			ie_r <= 1'b0;
			ps_r <= '0;
			done_r <= 1'b0;
			hold_r <= '0;
			act_r <= '0;
			result_r <= '0;
			prdata_r <= ACS_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			st_r <= ACS_IDLE;
			cnt_r <= '0;
			first_r <= 1'b1;
			auto_r <= 1'b0;
			sample_r <= 1'b0;
			irq_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			ate_r <= ate_nxt;
			free_r <= free_nxt;
			ie_r <= ie_nxt;
			ps_r <= ps_nxt;
			done_r <= done_nxt;
			hold_r <= hold_nxt;
			act_r <= act_nxt;
			result_r <= result_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			first_r <= first_nxt;
			auto_r <= auto_nxt;
			sample_r <= sample_nxt;
			irq_r <= irq_nxt;
			halt_r <= halt_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign active_sel = act_r;
	assign sample_hold = sample_r;
	assign conv_active = (st_r == ACS_CONV);
	assign conv_irq = irq_r;
	assign analog_on = en_r;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_SINGLE_DONE: assert property (complete && !free_mode && en_r && !auto_go
		|=> st_r == ACS_IDLE && done_r)
		else $error("single conversion did not end with done set");
	AST_FREE_RESTART: assert property (complete && free_mode && en_r
		|=> st_r == ACS_CONV && cnt_r == 6'h00)
		else $error("free running conversion did not restart");
	AST_START_EDGE: assert property (st_r == ACS_WAIT_EDGE && adc_rise && en_r && !auto_go
		|=> st_r == ACS_CONV && cnt_r == 6'h00)
		else $error("software start missed converter rising edge");
	AST_SEL_LOCKED: assert property (st_r == ACS_CONV && !unlock && en_r && !auto_go
		|=> $stable(act_r))
		else $error("active selection changed while locked");
	AST_SEL_UNLOCK: assert property (st_r == ACS_CONV && unlock
		|=> act_r == $past(hold_r))
		else $error("selection not copied in last converter cycle");
	AST_EDGE_IGNORED: assert property (st_r == ACS_CONV && trig_rise && cnt_r != 6'h00 && !complete
		&& en_r |=> cnt_r != 6'h00)
		else $error("trigger edge restarted a running conversion");
	AST_FULL_SCALE: assert property (complete && over_range && en_r
		|=> result_r == ACS_FULL_SCALE)
		else $error("over range input did not give full scale");
	AST_FIRST_SAMPLE: assert property (sample_r && first_r |-> cnt_r == 6'h1b)
		else $error("first conversion sampled at wrong time");
	AST_NORM_SAMPLE: assert property (sample_r && !first_r && !auto_r |-> cnt_r == 6'h03)
		else $error("normal conversion sampled at wrong time");
	AST_AUTO_SAMPLE: assert property (sample_r && !first_r && auto_r |-> cnt_r == 6'h04)
		else $error("auto conversion sampled at wrong time");
	AST_AUTO_CLEAR: assert property (auto_go
		|=> st_r == ACS_CONV && cnt_r == 6'h00 && !adc_rise && !half_tick)
		else $error("auto trigger did not restart prescaler");
	AST_IRQ: assert property (done_r && ie_r |-> conv_irq)
		else $error("completion request missing");
	AST_SYNC: assert property ($rose(trig_in) ##1 trig_in [*4] |-> ##0 trig_lvl_r)
		else $error("trigger level not taken after synchronizer");

	COV_FREE: cover property (complete && free_mode);
	COV_AUTO: cover property (auto_go ##[1:200] complete);
	COV_SLEEP: cover property (sleep_noise_mode && cpu_halted && st_r == ACS_WAIT_EDGE);
	COV_FIRST: cover property (complete && first_r);
endmodule // acs_adc_conversion_sequencer
`default_nettype wire

/* File: sim/acs_core_model.sv */
// Purpose: behavioural analog core and input multiplexer for the sequencer
// Assumes: the result is formed from the selection seen at the sample pulse
// Notes: channel 4'hf stands for an input above the selected reference
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire acs_pkg::acs_sel_t active_sel,
	input wire logic sample_hold,
	input wire logic analog_on,
	output logic over_range,
	output logic [9:0] core_result
);
	import acs_pkg::*;
	// result held from sample to next sample; scrambled while powered down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_result <= 10'h2aa;
			over_range <= 1'b0;
		end else if (sample_hold) begin
			core_result <= (active_sel.chan_sel == 4'hf) ? 10'h155 : {active_sel, 4'h9};
			over_range <= (active_sel.chan_sel == 4'hf);
		end else if (!analog_on) begin
			core_result <= ~core_result;
		end
	end
endmodule // acs_core_model
`default_nettype wire

/* File: sim/acs_adc_conversion_sequencer_tb.sv */
// Purpose: self-checking bench for the conversion sequencer
// Assumes: prescaler select 0 outside the div4 case, so one converter half period is one pclk
// Notes: conversion lengths are counted in pclk cycles of conv_active
`timescale 1ns/1ps
`default_nettype none
module acs_adc_conversion_sequencer_tb;
	import acs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic trig_in, sleep_noise_mode, cpu_halted, over_range;
	logic sample_hold, conv_active, conv_irq, analog_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] core_result;
	acs_sel_t active_sel;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	acs_adc_conversion_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in),
		.sleep_noise_mode(sleep_noise_mode), .cpu_halted(cpu_halted), .over_range(over_range),
		.core_result(core_result), .active_sel(active_sel), .sample_hold(sample_hold),
		.conv_active(conv_active), .conv_irq(conv_irq), .analog_on(analog_on));
	acs_core_model i_core (.pclk(pclk), .presetn(presetn), .active_sel(active_sel),
		.sample_hold(sample_hold), .analog_on(analog_on), .over_range(over_range),
		.core_result(core_result));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask
	// length of conv_active and offset of the sample pulse inside it
	task automatic meas(input int el, input int es, input string nm);
		int len = 0;
		int samp = -1;
		while (conv_active !== 1'b1 && len < 300) begin
			@(posedge pclk);
			len++;
		end
		len = 0;
		while (conv_active === 1'b1 && len < 300) begin
			if (sample_hold === 1'b1) samp = len;
			len++;
			@(posedge pclk);
		end
		chk(nm, el, len);
		chk(nm, es, samp);
	endtask
	task automatic gap(input int e, input string nm);
		int n = 0;
		while (sample_hold !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sample_hold !== 1'b1 && n < 300);
		chk(nm, e, n);
	endtask
	task automatic clr;
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0031);
		repeat (2) @(posedge pclk);
		chk("irq_clear", 0, conv_irq);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		trig_in = 1'b0;
		sleep_noise_mode = 1'b0;
		cpu_halted = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ACS_OFS_STAT, 32'h0000_0200, "stat_reset");
		rdc(ACS_OFS_CTRL, 32'h0000_0000, "ctrl_reset");
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("slverr", 1, err);
		apb(1'b1, ACS_OFS_SEL, 32'h0000_0013);
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0023);
		meas(50, 27, "first");
		repeat (2) @(posedge pclk);
		chk("irq", 1, conv_irq);
		rdc(ACS_OFS_DATA, 32'h0000_0139, "data");
		rdc(ACS_OFS_CTRL, 32'h0000_0031, "ctrl_done");
		rdc(ACS_OFS_STAT, 32'h0000_0013, "stat");
		clr();
		apb(1'b1, ACS_OFS_SEL, 32'h0000_0025);
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0023);
		fork
			meas(26, 3, "normal");
			begin
				wait (conv_active === 1'b1);
				apb(1'b1, ACS_OFS_SEL, 32'h0000_000f);
				chk("locked", 32'h0000_0025, {26'h0, active_sel});
			end
		join
		chk("resumed", 32'h0000_000f, {26'h0, active_sel});
		rdc(ACS_OFS_DATA, 32'h0000_0259, "data_old_sel");
		clr();
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0023);
		meas(26, 3, "over");
		rdc(ACS_OFS_DATA, 32'h0000_03ff, "full_scale");
		clr();
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_00a3);
		meas(52, 6, "div4");
		clr();
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0025);
		fork
			meas(28, 5, "auto");
			begin
				trig_in <= 1'b1;
				repeat (10) @(posedge pclk);
				trig_in <= 1'b0;
				repeat (3) @(posedge pclk);
				trig_in <= 1'b1;
			end
		join
		repeat (20) @(posedge pclk);
		chk("ignored", 0, conv_active);
		trig_in <= 1'b0;
		clr();
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_002f);
		gap(26, "free_gap");
		apb(1'b0, ACS_OFS_CTRL, 32'h0000_0000);
		chk("free_start", 1, rd[1]);
		chk("free_busy", 1, conv_active);
		apb(1'b1, ACS_OFS_CTRL, 32'h0000_0021);
		repeat (60) @(posedge pclk);
		chk("free_stop", 0, conv_active);
		clr();
		sleep_noise_mode <= 1'b1;
		cpu_halted <= 1'b1;
		fork
			meas(26, 3, "sleep");
			begin
				repeat (6) @(posedge pclk);
				cpu_halted <= 1'b0;
			end
		join
		repeat (2) @(posedge pclk);
		chk("wake_irq", 1, conv_irq);
		sleep_noise_mode <= 1'b0;
		clr();
		cpu_halted <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("other_sleep_on", 1, analog_on);
		chk("other_sleep_idle", 0, conv_active);
		cpu_halted <= 1'b0;
		report_and_stop();
	end
endmodule // acs_adc_conversion_sequencer_tb
`default_nettype wire
